//--- hw/tscp_pkg.sv
// Purpose: Shared constants of the transmitter serial configuration port.
// Assumes: A 100 MHz core clock.
// Notes:   Latch layouts and register offsets live here only.
`default_nettype none
package tscp_pkg;
   localparam int          WORD_W      = 24;
   localparam logic [1:0]  SEL_REF     = 2'h0;
   localparam logic [1:0]  SEL_DIV     = 2'h1;
   localparam logic [1:0]  SEL_MOD     = 2'h2;
   localparam logic [1:0]  SEL_FUNC    = 2'h3;
   localparam int          SEL_LSB     = 0;
   localparam int          OSC_BIT     = 2;
   localparam int          STAGE_BIT   = 3;
   localparam int          MON_LSB     = 13;
   localparam int          BAND_BIT    = 22;
   localparam int          SCHEME_LSB  = 2;
   localparam int          HIGH_LSB    = 4;
   localparam int          LOW_LSB     = 11;
   localparam int          CODE_W      = 7;
   localparam int          LEVEL_W     = 5;
   localparam logic [23:0] LATCH_RST   = 24'h000000;
   localparam logic [1:0]  SCH_FSK     = 2'h0;
   localparam logic [1:0]  SCH_ASK     = 2'h2;
   localparam logic [1:0]  SCH_OOK     = 2'h3;
   localparam logic [3:0]  MON_REG_RDY = 4'h0;
   localparam logic [3:0]  MON_LOCK    = 4'h1;
   localparam logic [3:0]  MON_TX_BIT  = 4'h2;
   localparam logic [3:0]  MON_LOW     = 4'h3;
   localparam logic [7:0]  LOCK_SET_NS = 8'h0f;
   localparam logic [7:0]  LOCK_CLR_NS = 8'h19;
   localparam logic [2:0]  LOCK_RUN    = 3'h5;
   localparam int          CLK_MHZ     = 100;
   localparam int          REG_UP_US   = 50;
   localparam int          REG_UP_CYC  = REG_UP_US * CLK_MHZ;
   localparam logic [7:0]  ADR_REF     = 8'h00;
   localparam logic [7:0]  ADR_DIV     = 8'h04;
   localparam logic [7:0]  ADR_MOD     = 8'h08;
   localparam logic [7:0]  ADR_FUNC    = 8'h0c;
   localparam logic [7:0]  ADR_STATUS  = 8'h10;
   localparam logic [7:0]  ADR_MASK    = 8'h14;
   localparam logic [7:0]  ADR_LIVE    = 8'h18;
   localparam logic [3:0]  MASK_RST    = 4'h0;
   localparam int          EV_LOADED   = 0;
   localparam int          EV_LOCKED   = 1;
   localparam int          EV_UNLOCK   = 2;
   localparam int          EV_CE_DOWN  = 3;
endpackage
`default_nettype wire

//--- hw/tscp_lock_if.sv
// Purpose: Carries phase comparator results to the lock detector.
// Assumes: All signals are on core_clk.
// Notes:   One strobe per comparison cycle.
`default_nettype none
interface tscp_lock_if;
   logic       cmp_strobe;
   logic [7:0] cmp_error_ns;
   logic       lock;
   modport core (output cmp_strobe, output cmp_error_ns, input lock);
   modport det  (input cmp_strobe, input cmp_error_ns, output lock);
endinterface
`default_nettype wire

//--- hw/tscp_sync.sv
// Purpose: Two-flop synchroniser for asynchronous pins.
// Assumes: Inputs change slowly against core_clk.
// Notes:   Only the second stage leaves this module.
`default_nettype none
module tscp_sync #(
   parameter int W = 1
) (
   input  wire logic         core_clk,
   input  wire logic         rstn,
   input  wire logic         clk_en,
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] sync_out
);
   logic [W-1:0] meta;
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         meta     <= '0;
         sync_out <= '0;
      end else if (clk_en) begin
         meta     <= async_in;
         sync_out <= meta;
      end
   end
endmodule
`default_nettype wire

//--- hw/tscp_lock.sv
// Purpose: Digital lock indication from phase comparator errors.
// Assumes: One cmp_strobe per comparison with its error in ns.
// Notes:   Errors between the two thresholds keep the lock state but reset the run count.
`default_nettype none
module tscp_lock (
   input  wire logic core_clk,
   input  wire logic rstn,
   input  wire logic clk_en,
   input  wire logic clear,
   tscp_lock_if.det  lk
);
   logic [2:0] run;
   logic [2:0] next_run;
   wire        good = lk.cmp_error_ns < tscp_pkg::LOCK_SET_NS;
   wire        bad  = lk.cmp_error_ns >= tscp_pkg::LOCK_CLR_NS;
   wire        set  = lk.cmp_strobe && good && run == tscp_pkg::LOCK_RUN - 3'h1;
   assign next_run = !lk.cmp_strobe ? run : good ? (set ? run : run + 3'h1) : 3'h0;
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         run     <= 3'h0;
         lk.lock <= 1'b0;
      end else if (clk_en) begin
         if (clear) begin
            run     <= 3'h0;
            lk.lock <= 1'b0;
         end else begin
            run <= next_run;
            if (set) // R11
               lk.lock <= 1'b1;
            else if (lk.cmp_strobe && bad) // R12
               lk.lock <= 1'b0;
         end
      end
   end
   lock_set_a : assert property (@(posedge core_clk) disable iff (!rstn) // R11
      clk_en && !clear && set |=> lk.lock)
      else $error("lock not raised after five good comparisons");
   lock_drop_a : assert property (@(posedge core_clk) disable iff (!rstn) // R12
      clk_en && !clear && lk.lock && lk.cmp_strobe && bad |=> !lk.lock)
      else $error("lock held past the release threshold");
   lock_hold_a : assert property (@(posedge core_clk) disable iff (!rstn) // R12
      clk_en && !clear && lk.lock && !(lk.cmp_strobe && bad) |=> lk.lock)
      else $error("lock dropped without a large error");
endmodule
`default_nettype wire

//--- hw/tscp_top.sv
// Purpose: Three-wire configuration port with four latches and their digital uses.
// Assumes: Serial pins are asynchronous; comparator results are on core_clk.
// Notes:   Latches are readable over classic Wishbone.
//
// Summary of operation
// (R1) Four 24-bit latches loaded from one 24-bit shift register.
// (R2) Data arrives MSB first, one bit per rising serial clock edge.
// (R3) Rising load strobe copies the shift register into the chosen latch.
// (R4) Bits one and zero of the word select the latch.
// (R5) 00 reference, 01 divider, 10 modulation, 11 function latch.
// (R6) With chip enable low all serial activity is ignored.
// (R7) Chip enable low stops the regulator and clears every latch.
// (R8) Host waits for regulator ready on the monitor output first.
// (R9) Monitor output shows regulator ready by default.
// (R10) Four-bit monitor select in the function latch picks the monitor source.
// (R11) Lock rises after five comparisons each below 15 ns error.
// (R12) Lock stays until a 25 ns error, then falls.
// (R13) Oscillator power bit turns the oscillator on or off.
// (R14) Band bit in the divider latch halves the oscillator output.
// (R15) Clearing output stage power bit powers the stage down.
// (R16) Power code: upper two bits range, lower five bits level.
// (R17) Amplitude keying uses high code for data one, low code for zero.
// (R18) Scheme 00 frequency keying, 10 amplitude keying, 11 on-off keying.
// (R19) The latched word is the last 24 bits shifted before the strobe.
`default_nettype none
module tscp_top #(
   parameter int REG_UP_CYC = tscp_pkg::REG_UP_CYC
) (
   input  wire logic        core_clk,
   input  wire logic        rstn,
   input  wire logic        clk_en,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   output logic             irq,
   input  wire logic        ser_clk,
   input  wire logic        ser_data,
   input  wire logic        load_strobe,
   input  wire logic        chip_enable,
   input  wire logic        transmit_bit_input,
   input  wire logic        cmp_strobe,
   input  wire logic [7:0]  cmp_error_ns,
   output logic             monitor_output,
   output logic             regulator_on,
   output logic             oscillator_power_on,
   output logic             output_stage_power_on,
   output logic             half_band_select,
   output logic [1:0]       power_range,
   output logic [4:0]       power_level
);
   localparam int          CW  = $clog2(REG_UP_CYC + 1);
   localparam logic [CW-1:0] UP_END = CW'(REG_UP_CYC);

   tscp_lock_if lk ();
   assign lk.cmp_strobe   = cmp_strobe;
   assign lk.cmp_error_ns = cmp_error_ns;

   // Serial pins, chip enable and transmit data cross in together.
   logic [4:0] pins_s;
   tscp_sync #(.W(5)) u_sync (
      .core_clk (core_clk),
      .rstn     (rstn),
      .clk_en   (clk_en),
      .async_in ({transmit_bit_input, chip_enable, load_strobe, ser_data, ser_clk}),
      .sync_out (pins_s)
   );
   wire s_clk  = pins_s[0];
   wire s_data = pins_s[1];
   wire s_load = pins_s[2];
   wire s_ce   = pins_s[3];
   wire s_tx   = pins_s[4];

   logic s_clk_d;
   logic s_load_d;
   logic s_ce_d;
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         s_clk_d  <= 1'b0;
         s_load_d <= 1'b0;
         s_ce_d   <= 1'b0;
      end else if (clk_en) begin
         s_clk_d  <= s_clk;
         s_load_d <= s_load;
         s_ce_d   <= s_ce;
      end
   end
   wire clk_rise  = s_clk & ~s_clk_d;
   wire load_rise = s_load & ~s_load_d;
   wire ce_fall   = s_ce_d & ~s_ce;

   // Regulator follows chip enable and reports ready after its start-up time.
   logic [CW-1:0] up_cnt;
   logic          reg_ready;
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         up_cnt    <= '0;
         reg_ready <= 1'b0;
      end else if (clk_en) begin
         if (!s_ce) begin // R7
            up_cnt    <= '0;
            reg_ready <= 1'b0;
         end else if (up_cnt != UP_END) begin
            up_cnt    <= up_cnt + CW'(1);
            reg_ready <= (up_cnt == UP_END - CW'(1));
         end
      end
   end

   // Shift register and the four latches.
   logic [23:0] shreg;
   logic [23:0] latch [4];
   wire  [1:0]  sel = shreg[tscp_pkg::SEL_LSB +: 2]; // R4
   wire         do_shift = s_ce & clk_rise; // R6
   wire         do_load  = s_ce & load_rise; // R6
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         shreg <= tscp_pkg::LATCH_RST;
      end else if (clk_en) begin
         if (!s_ce)
            shreg <= tscp_pkg::LATCH_RST; // R6
         else if (do_shift)
            shreg <= {shreg[22:0], s_data}; // R2 R19
      end
   end
   for (genvar i = 0; i < 4; i++) begin : g_latch
      always_ff @(posedge core_clk or negedge rstn) begin
         if (!rstn)
            latch[i] <= tscp_pkg::LATCH_RST;
         else if (clk_en) begin
            if (!s_ce)
               latch[i] <= tscp_pkg::LATCH_RST; // R7
            else if (do_load && sel == 2'(i))
               latch[i] <= shreg; // R1 R3 R5
         end
      end
   end
   wire [23:0] ref_w  = latch[tscp_pkg::SEL_REF];
   wire [23:0] div_w  = latch[tscp_pkg::SEL_DIV];
   wire [23:0] mod_w  = latch[tscp_pkg::SEL_MOD];
   wire [23:0] func_w = latch[tscp_pkg::SEL_FUNC];

   tscp_lock u_lock (
      .core_clk (core_clk),
      .rstn     (rstn),
      .clk_en   (clk_en),
      .clear    (~s_ce),
      .lk       (lk)
   );

   // Decoded configuration.
   wire [3:0] mon_sel  = func_w[tscp_pkg::MON_LSB +: 4];
   wire [1:0] scheme   = mod_w[tscp_pkg::SCHEME_LSB +: 2];
   wire [6:0] hi_code  = mod_w[tscp_pkg::HIGH_LSB +: tscp_pkg::CODE_W];
   wire [6:0] lo_code  = mod_w[tscp_pkg::LOW_LSB +: tscp_pkg::CODE_W];
   wire       is_ask   = scheme == tscp_pkg::SCH_ASK; // R18
   wire       is_ook   = scheme == tscp_pkg::SCH_OOK; // R18
   wire [6:0] act_code = (is_ask && !s_tx) ? lo_code : hi_code; // R17
   wire       ook_off  = is_ook && !s_tx;
   wire       next_mon = (mon_sel == tscp_pkg::MON_REG_RDY) ? reg_ready : // R9 R10
                         (mon_sel == tscp_pkg::MON_LOCK)    ? lk.lock :
                         (mon_sel == tscp_pkg::MON_TX_BIT)  ? s_tx : 1'b0;

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         monitor_output        <= 1'b0;
         regulator_on          <= 1'b0;
         oscillator_power_on   <= 1'b0;
         output_stage_power_on <= 1'b0;
         half_band_select      <= 1'b0;
         power_range           <= 2'h0;
         power_level           <= 5'h00;
      end else if (clk_en) begin
         monitor_output        <= next_mon; // R10
         regulator_on          <= s_ce; // R7
         oscillator_power_on   <= func_w[tscp_pkg::OSC_BIT]; // R13
         output_stage_power_on <= func_w[tscp_pkg::STAGE_BIT] & ~ook_off; // R15
         half_band_select      <= div_w[tscp_pkg::BAND_BIT]; // R14
         power_range           <= act_code[6:5]; // R16
         power_level           <= act_code[4:0]; // R16
      end
   end

   // Event flags: a read clears, but an event in the same cycle survives.
   logic       lock_d;
   logic [3:0] status;
   logic [3:0] mask;
   wire        bus_req  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   wire        wr_mask  = bus_req & wb_we_i & wb_sel_i[0] & (wb_adr_i == tscp_pkg::ADR_MASK);
   wire        rd_stat  = bus_req & ~wb_we_i & (wb_adr_i == tscp_pkg::ADR_STATUS);
   wire [3:0]  events   = {ce_fall, lock_d & ~lk.lock, lk.lock & ~lock_d, do_load};
   wire [3:0]  next_status = (rd_stat ? 4'h0 : status) | events;
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         lock_d <= 1'b0;
         status <= 4'h0;
         mask   <= tscp_pkg::MASK_RST;
         irq    <= 1'b0;
      end else if (clk_en) begin
         lock_d <= lk.lock;
         status <= next_status;
         if (wr_mask)
            mask <= wb_dat_i[3:0];
         irq <= |(next_status & mask);
      end
   end

   // Wishbone slave: one wait state, unmapped reads return zero.
   wire [31:0] rd_live = {27'h0, scheme, lk.lock, reg_ready, s_ce};
   wire [31:0] next_rd = (wb_adr_i == tscp_pkg::ADR_REF)    ? {8'h0, ref_w}  :
                         (wb_adr_i == tscp_pkg::ADR_DIV)    ? {8'h0, div_w}  :
                         (wb_adr_i == tscp_pkg::ADR_MOD)    ? {8'h0, mod_w}  :
                         (wb_adr_i == tscp_pkg::ADR_FUNC)   ? {8'h0, func_w} :
                         (wb_adr_i == tscp_pkg::ADR_STATUS) ? {28'h0, status} :
                         (wb_adr_i == tscp_pkg::ADR_MASK)   ? {28'h0, mask} :
                         (wb_adr_i == tscp_pkg::ADR_LIVE)   ? rd_live : 32'h0;
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0;
      end else if (clk_en) begin
         wb_ack_o <= bus_req;
         wb_dat_o <= bus_req ? next_rd : 32'h0;
      end
   end

   sequence word_shifted;
      clk_en && do_shift;
   endsequence
   sequence func_loaded;
      clk_en && do_load && sel == tscp_pkg::SEL_FUNC;
   endsequence

   shift_in_a : assert property (@(posedge core_clk) disable iff (!rstn) // R2
      word_shifted |=> shreg == {$past(shreg[22:0]), $past(s_data)})
      else $error("serial bit not shifted in at the low end");
   latch_copy_a : assert property (@(posedge core_clk) disable iff (!rstn) // R3
      func_loaded |=> func_w == $past(shreg))
      else $error("function latch did not take the shifted word");
   ref_select_a : assert property (@(posedge core_clk) disable iff (!rstn) // R5
      clk_en && do_load && sel == tscp_pkg::SEL_REF |=> ref_w == $past(shreg) && $stable(mod_w))
      else $error("reference word landed in the wrong latch");
   ce_clear_a : assert property (@(posedge core_clk) disable iff (!rstn) // R7
      clk_en && !s_ce |=> ref_w == 24'h0 && div_w == 24'h0 && mod_w == 24'h0 && func_w == 24'h0)
      else $error("latches not cleared with chip enable low");
   ce_ignore_a : assert property (@(posedge core_clk) disable iff (!rstn) // R6
      clk_en && !s_ce |=> shreg == 24'h0 &&
         status[tscp_pkg::EV_LOADED] == ($past(status[tscp_pkg::EV_LOADED]) && !$past(rd_stat)))
      else $error("serial activity accepted while disabled");
   mon_default_a : assert property (@(posedge core_clk) disable iff (!rstn) // R9
      clk_en && mon_sel == tscp_pkg::MON_REG_RDY |=> monitor_output == $past(reg_ready))
      else $error("monitor output not showing regulator ready");
   osc_power_a : assert property (@(posedge core_clk) disable iff (!rstn) // R13
      func_loaded ##1 clk_en |=> oscillator_power_on == func_w[tscp_pkg::OSC_BIT])
      else $error("oscillator power does not follow its bit");
   band_sel_a : assert property (@(posedge core_clk) disable iff (!rstn) // R14
      clk_en |=> half_band_select == $past(div_w[tscp_pkg::BAND_BIT]))
      else $error("band select does not follow the divider latch");
   ask_code_a : assert property (@(posedge core_clk) disable iff (!rstn) // R17
      clk_en && is_ask && !s_tx |=> {power_range, power_level} == $past(lo_code))
      else $error("amplitude keying zero did not use the low code");
   stage_off_a : assert property (@(posedge core_clk) disable iff (!rstn) // R15
      clk_en && !func_w[tscp_pkg::STAGE_BIT] |=> !output_stage_power_on)
      else $error("output stage on with its power bit clear");
endmodule
`default_nettype wire

//--- dv/tscp_host_model.sv
// Purpose: Host side of the three-wire programming port.
// Assumes: Called right after a core_clk edge; one serial clock phase is ph core cycles.
// Notes:   The serial clock runs only inside frames; an idle data line shows the inverse of its last bit.
`default_nettype none
module tscp_host_model (
   input  wire logic core_clk,
   input  wire logic monitor_output,
   output var  logic ser_clk,
   output var  logic ser_data,
   output var  logic load_strobe,
   output var  logic chip_enable
);
   timeunit 1ns;
   timeprecision 100ps;
   int idle_gap = 0;
   int ph       = 8;
   initial begin
      ser_clk     = 1'b0;
      ser_data    = 1'b0;
      load_strobe = 1'b0;
      chip_enable = 1'b0;
   end
   // A stalling host keeps the clock low and scrambles data so no stale bit can pass as valid.
   task automatic shift_bit(input logic b);
      ser_data <= b;
      repeat (ph) @(posedge core_clk);
      ser_clk <= 1'b1;
      repeat (ph) @(posedge core_clk);
      ser_clk <= 1'b0;
      repeat (idle_gap) begin
         ser_data <= ~ser_data;
         @(posedge core_clk);
      end
   endtask
   task automatic send_word(input logic [23:0] w);
      @(posedge core_clk);
      for (int i = 23; i >= 0; i--) begin
         shift_bit(w[i]);
      end
      repeat (ph) @(posedge core_clk);
      ser_data    <= ~w[0];
      load_strobe <= 1'b1;
      repeat (ph) @(posedge core_clk);
      load_strobe <= 1'b0;
   endtask
   task automatic power_up(output logic ready);
      int n;
      n = 0;
      @(posedge core_clk);
      chip_enable <= 1'b1;
      // Waits up to 500 cycles for the monitor output to show ready; words sent earlier, with chip enable low, are ignored.
      while (monitor_output !== 1'b1 && n < 500) begin
         @(posedge core_clk);
         n++;
      end
      ready = monitor_output;
   endtask
   task automatic power_down();
      @(posedge core_clk);
      chip_enable <= 1'b0;
   endtask
endmodule
`default_nettype wire

//--- dv/test_transmitter_serial_config_port.sv
// Purpose: Self-checking bench for the transmitter serial configuration port.
// Assumes: Regulator start-up shortened to 20 cycles.
// Notes:   Latches are checked by reading them back over Wishbone.
`default_nettype none
module test_transmitter_serial_config_port;
   timeunit 1ns;
   timeprecision 100ps;
   logic        core_clk = 1'b0;
   logic        rstn     = 1'b0;
   logic        wb_cyc   = 1'b0;
   logic        wb_stb   = 1'b0;
   logic        wb_we    = 1'b0;
   logic [7:0]  wb_adr   = 8'h00;
   logic [31:0] wb_dat   = 32'h0;
   logic        tx_bit   = 1'b0;
   logic        cmp_stb  = 1'b0;
   logic        clk_en   = 1'b1;
   logic [3:0]  wb_sel   = 4'h0;
   logic [7:0]  cmp_err  = 8'h00;
   logic [31:0] rng      = 32'hc;
   logic [31:0] wb_rdat, rd;
   logic        wb_ack, irq, ser_clk, ser_data, load_strobe, chip_enable, mon, reg_on, osc_on, stage_on;
   logic        half_band, rdy;
   logic [1:0]  p_range;
   logic [4:0]  p_level;
   logic [23:0] w;
   logic [23:0] exp_latch [4] = '{default: 24'h0};
   int          failures = 0;
   int          checks_done = 0;
   int          cyc_count = 0;
   tscp_top #(.REG_UP_CYC(20)) u_tscp_top (
      .core_clk(core_clk), .rstn(rstn), .clk_en(clk_en), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
      .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(wb_rdat),
      .wb_ack_o(wb_ack), .irq(irq), .ser_clk(ser_clk), .ser_data(ser_data), .load_strobe(load_strobe),
      .chip_enable(chip_enable), .transmit_bit_input(tx_bit), .cmp_strobe(cmp_stb), .cmp_error_ns(cmp_err),
      .monitor_output(mon), .regulator_on(reg_on), .oscillator_power_on(osc_on),
      .output_stage_power_on(stage_on), .half_band_select(half_band), .power_range(p_range),
      .power_level(p_level));
   tscp_host_model u_host (.core_clk(core_clk), .monitor_output(mon), .ser_clk(ser_clk),
      .ser_data(ser_data), .load_strobe(load_strobe), .chip_enable(chip_enable));
   always #5 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      cyc_count++;
      if (cyc_count == 40000) begin
         failures++;
         stop_test();
      end
   end
   function automatic logic [31:0] rnd();
      rng = rng ^ (rng << 13);
      rng = rng ^ (rng >> 17);
      rng = rng ^ (rng << 5);
      return rng;
   endfunction
   function automatic logic [23:0] mk_word(input logic [1:0] sel);
      logic [31:0] r;
      r = rnd();
      return {r[23:2], sel};
   endfunction
   function automatic logic [23:0] mk_func(input logic osc, input logic st, input logic [3:0] m);
      logic [23:0] f;
      f = mk_word(tscp_pkg::SEL_FUNC);
      f[tscp_pkg::OSC_BIT] = osc;
      f[tscp_pkg::STAGE_BIT] = st;
      f[tscp_pkg::MON_LSB +: 4] = m;
      return f;
   endfunction
   function automatic logic [6:0] exp_code(input logic [23:0] m, input logic tx);
      if (m[tscp_pkg::SCHEME_LSB +: 2] == tscp_pkg::SCH_ASK && !tx) return m[tscp_pkg::LOW_LSB +: 7];
      return m[tscp_pkg::HIGH_LSB +: 7];
   endfunction
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
      checks_done++;
      if (seen !== exp) begin
         failures++;
         $display("MISMATCH at %0t: %s seen %h expected %h", $time, msg, seen, exp);
      end
   endtask
   task automatic wb_xfer(input logic we, input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_sel <= 4'hf;
      wb_we  <= we;
      wb_adr <= a;
      wb_dat <= d;
      do @(posedge core_clk); while (wb_ack !== 1'b1);
      rd = wb_rdat;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      wb_sel <= 4'h0;
   endtask
   task automatic check_latches();
      for (int k = 0; k < 4; k++) begin
         wb_xfer(1'b0, tscp_pkg::ADR_REF + 8'(4 * k), 32'h0);
         chk(rd, {8'h00, exp_latch[k]}, "latch");
      end
   endtask
   task automatic cmp_pulse(input logic [7:0] e);
      @(posedge core_clk);
      cmp_stb <= 1'b1;
      cmp_err <= e;
      @(posedge core_clk);
      cmp_stb <= 1'b0;
      repeat (4) @(posedge core_clk);
   endtask
   task automatic load(input logic [23:0] v);
      u_host.send_word(v);
      if (chip_enable) exp_latch[v[1:0]] = v;
      repeat (8) @(posedge core_clk);
   endtask
   task automatic stop_test();
      $display("Checks done: %0d, failures: %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   initial begin
      logic [1:0] sch [4];
      sch = '{tscp_pkg::SCH_FSK, tscp_pkg::SCH_ASK, tscp_pkg::SCH_OOK, 2'h1};
      repeat (3) @(posedge core_clk);
      rstn <= 1'b1;
      wb_xfer(1'b0, tscp_pkg::ADR_MASK, 32'h0);
      chk(rd, 32'(tscp_pkg::MASK_RST), "mask reset");
      chk(reg_on, 0, "regulator off");
      check_latches();
      u_host.power_up(rdy);
      chk(rdy, 1, "regulator ready");
      for (int k = 0; k < 12; k++) begin
         u_host.idle_gap = (k == 5) ? 6 : 0;
         load(mk_word(2'(k)));
         if (k == 0) chk(irq, 0, "masked irq");
         check_latches();
      end
      wb_xfer(1'b1, tscp_pkg::ADR_MASK, 32'h1);
      wb_xfer(1'b0, tscp_pkg::ADR_MASK, 32'h0);
      chk(rd, 32'h1, "mask readback");
      wb_xfer(1'b0, tscp_pkg::ADR_STATUS, 32'h0);
      chk(irq, 0, "irq idle");
      u_host.shift_bit(1'b1);
      u_host.shift_bit(1'b0);
      w = mk_word(tscp_pkg::SEL_DIV);
      load(w);
      chk(irq, 1, "irq on load");
      chk(half_band, w[tscp_pkg::BAND_BIT], "band");
      wb_xfer(1'b0, tscp_pkg::ADR_STATUS, 32'h0);
      chk(rd[tscp_pkg::EV_LOADED], 1, "status loaded");
      repeat (2) @(posedge core_clk);
      chk(irq, 0, "irq cleared");
      check_latches();
      w = mk_word(tscp_pkg::SEL_MOD);
      w[tscp_pkg::SCHEME_LSB +: 2] = tscp_pkg::SCH_FSK;
      load(w);
      for (int i = 0; i < 4; i++) begin
         tx_bit <= i[0];
         load(mk_func(i[0], i[1], i < 2 ? tscp_pkg::MON_TX_BIT : i == 2 ? tscp_pkg::MON_REG_RDY : tscp_pkg::MON_LOW));
         chk(osc_on, i[0], "osc");
         chk(stage_on, i[1], "stage");
         chk(mon, i == 1 || i == 2, "monitor");
      end
      for (int s = 0; s < 4; s++) begin
         w = mk_word(tscp_pkg::SEL_MOD);
         w[tscp_pkg::SCHEME_LSB +: 2] = sch[s];
         load(w);
         for (int t = 0; t < 2; t++) begin
            @(posedge core_clk);
            tx_bit <= t[0];
            repeat (8) @(posedge core_clk);
            chk(stage_on, !(sch[s] == tscp_pkg::SCH_OOK && t == 0), "keyed stage");
            if (!(sch[s] == tscp_pkg::SCH_OOK && t == 0)) chk({p_range, p_level}, exp_code(w, t[0]), "code");
         end
      end
      load(mk_func(1'b1, 1'b1, tscp_pkg::MON_LOCK));
      for (int k = 0; k < 10; k++) begin
         cmp_pulse(k == 4 ? tscp_pkg::LOCK_SET_NS : 8'(rnd() % 15));
         chk(mon, k == 9, "lock gain");
      end
      for (int k = 0; k < 4; k++) begin
         cmp_pulse(tscp_pkg::LOCK_SET_NS + 8'(rnd() % 10));
         chk(mon, 1, "lock held");
      end
      // A large error while the clock enable is low must leave the lock untouched.
      clk_en <= 1'b0;
      cmp_pulse(tscp_pkg::LOCK_CLR_NS);
      clk_en <= 1'b1;
      repeat (2) @(posedge core_clk);
      chk(mon, 1, "lock frozen");
      cmp_pulse(tscp_pkg::LOCK_CLR_NS);
      chk(mon, 0, "lock lost");
      u_host.power_down();
      repeat (6) @(posedge core_clk);
      chk(reg_on, 0, "regulator down");
      exp_latch = '{default: 24'h0};
      wb_xfer(1'b0, tscp_pkg::ADR_STATUS, 32'h0);
      chk(rd, 32'h0000000f, "all events");
      load(mk_word(tscp_pkg::SEL_FUNC));
      check_latches();
      wb_xfer(1'b0, tscp_pkg::ADR_STATUS, 32'h0);
      chk(rd, 32'h0, "load ignored");
      wb_xfer(1'b0, 8'h40, 32'h0);
      chk(rd, 32'h0, "unmapped");
      u_host.power_up(rdy);
      chk(rdy, 1, "ready again");
      wb_xfer(1'b0, tscp_pkg::ADR_LIVE, 32'h0);
      chk(rd, 32'h00000003, "live state");
      stop_test();
   end
endmodule
`default_nettype wire
